// file: rtl/eag_pkg.sv
// Shared types and constants of the effective address generator
package eag_pkg;

   localparam int ADDR_W   = 24;
   localparam int DATA_W   = 32;
   localparam int NREGS    = 8;
   localparam int REG_AW   = 3;
   localparam int BITNUM_W = 3;
   localparam int TRAP_W   = 2;

   typedef enum logic [3:0] {
      eag_m_reg_direct,
      eag_m_reg_ind,
      eag_m_disp16,
      eag_m_disp24,
      eag_m_post_inc,
      eag_m_pre_dec,
      eag_m_abs8,
      eag_m_abs16,
      eag_m_abs24,
      eag_m_imm,
      eag_m_pc_rel8,
      eag_m_pc_rel16,
      eag_m_mem_ind
   } eag_mode_t;

   typedef enum logic [2:0] {
      eag_op_alu,
      eag_op_xfer,
      eag_op_bit,
      eag_op_branch,
      eag_op_jump,
      eag_op_trap
   } eag_op_t;

   typedef enum logic [1:0] {
      eag_sz_byte,
      eag_sz_word,
      eag_sz_long
   } eag_size_t;

   // Upper fill of the short absolute and pointer indirect forms
   localparam logic [15:0]       ABS8_FILL  = 16'hffff;
   localparam logic [15:0]       PTR_FILL   = 16'h0000;
   // Address mask of the 1-Mbyte modes
   localparam logic [ADDR_W-1:0] MB1_MASK   = 24'h0fffff;
   localparam logic [DATA_W-1:0] STEP_BYTE  = 32'h00000001;
   localparam logic [DATA_W-1:0] STEP_WORD  = 32'h00000002;
   localparam logic [DATA_W-1:0] STEP_LONG  = 32'h00000004;
   localparam logic [ADDR_W-1:0] RST_ADDR   = 24'h000000;
   localparam logic [DATA_W-1:0] RST_WORD   = 32'h00000000;
   // Field positions inside a general register
   localparam int HI_BYTE_LSB = 8;
   localparam int EXT_HALF_LSB = 16;
   // Cycles from an accepted request to done, all modes but memory indirect
   localparam int LATENCY = 2;

endpackage : eag_pkg

// file: rtl/eag_rf_if.sv
// Port bundle between the address generator and its general register store
`timescale 1ns/1ps
interface eag_rf_if;
   logic [eag_pkg::REG_AW-1:0] rd_addr;
   logic [eag_pkg::DATA_W-1:0] rd_data;
   logic [eag_pkg::REG_AW-1:0] rd2_addr;
   logic [eag_pkg::DATA_W-1:0] rd2_data;
   logic                       wr_en;
   logic [eag_pkg::REG_AW-1:0] wr_addr;
   logic [eag_pkg::DATA_W-1:0] wr_data;

   modport core  (output rd_addr, output rd2_addr, output wr_en, output wr_addr,
                  output wr_data, input rd_data, input rd2_data);
   modport store (input rd_addr, input rd2_addr, input wr_en, input wr_addr,
                  input wr_data, output rd_data, output rd2_data);
endinterface : eag_rf_if

// file: rtl/eag_regfile.sv
// Eight 32-bit general registers, two registered read ports, one write port
`timescale 1ns/1ps
module eag_regfile (
   input wire logic clk,
   input wire logic rst_n,
   eag_rf_if.store  rf
);
   logic [eag_pkg::DATA_W-1:0] mem_q [eag_pkg::NREGS];
   logic [eag_pkg::DATA_W-1:0] rd_q;
   logic [eag_pkg::DATA_W-1:0] rd2_q;

   genvar g;
   generate
      for (g = 0; g < eag_pkg::NREGS; g++) begin : g_reg
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               mem_q[g] <= eag_pkg::RST_WORD;
            end else if (rf.wr_en && rf.wr_addr == g[eag_pkg::REG_AW-1:0]) begin
               mem_q[g] <= rf.wr_data;
            end
         end
      end
   endgenerate

   // Read returns the value held before a same-cycle write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_q  <= eag_pkg::RST_WORD;
         rd2_q <= eag_pkg::RST_WORD;
      end else begin
         rd_q  <= mem_q[rf.rd_addr];
         rd2_q <= mem_q[rf.rd2_addr];
      end
   end

   assign rf.rd_data  = rd_q;
   assign rf.rd2_data = rd2_q;
endmodule : eag_regfile

// file: rtl/eag_top.sv
// Effective address generator: mode decode, address forming, register update
// How it works
// RULE1: ALU operands: register direct or immediate only
// RULE2: Transfers: all modes but PC-relative, memory indirect
// RULE3: Bit ops: direct, indirect, short absolute; bit source
// RULE4: Direct mode picks byte half, word half, longword
// RULE5: Indirect uses register low 24 bits
// RULE6: Displacement added, low 24 bits; 16-bit sign-extended
// RULE7: Post-increment: access first, then add 1/2/4
// RULE8: Pre-decrement: subtract 1/2/4, write back, use
// RULE9: Software keeps stepped register even for words
// RULE10: Short absolute fills upper 16 bits with ones
// RULE11: 16-bit absolute sign-extends bit 15 upward
// RULE12: 24-bit absolute used unmodified
// RULE13: Immediate supplies 8, 16 or 32 bit operand
// RULE14: Bit number from 3-bit immediate field
// RULE15: Trap instruction carries 2-bit vector selector
// RULE16: PC-relative: sign-extend, add next instruction address
// RULE17: Branch reach -126..+128 or -32766..+32768 bytes
// RULE18: Software keeps relative branch targets even
// RULE19: Memory indirect: fetch longword, drop first byte
// RULE20: Pointer address zero-extended to 0..255
// RULE21: Odd word, longword or branch address forced even
// RULE22: 1-Mbyte modes drop upper 4 address bits
`timescale 1ns/1ps
module eag_top (
   input  wire logic                            clk,
   input  wire logic                            rst_n,
   input  wire logic                            req_valid,
   input  wire eag_pkg::eag_op_t                req_op,
   input  wire eag_pkg::eag_mode_t              req_mode,
   input  wire eag_pkg::eag_size_t              req_size,
   input  wire logic [3:0]                      req_reg,
   input  wire logic [eag_pkg::REG_AW-1:0]      req_bit_reg,
   input  wire logic                            req_bit_from_reg,
   input  wire logic [eag_pkg::BITNUM_W-1:0]    req_bit_imm,
   input  wire logic [eag_pkg::DATA_W-1:0]      req_ext,
   input  wire logic [eag_pkg::ADDR_W-1:0]      req_pc_next,
   input  wire logic                            mode_1mb,
   input  wire logic                            ext_wr_en,
   input  wire logic [eag_pkg::REG_AW-1:0]      ext_wr_reg,
   input  wire logic [eag_pkg::DATA_W-1:0]      ext_wr_data,
   input  wire logic                            mem_rd_valid,
   input  wire logic [eag_pkg::DATA_W-1:0]      mem_rd_data,
   output logic                                 busy,
   output logic                                 done,
   output logic                                 illegal,
   output logic [eag_pkg::ADDR_W-1:0]           ea,
   output logic [eag_pkg::DATA_W-1:0]           operand,
   output logic [eag_pkg::BITNUM_W-1:0]         bit_num,
   output logic [eag_pkg::TRAP_W-1:0]           trap_vec,
   output logic                                 mem_rd_req,
   output logic [eag_pkg::ADDR_W-1:0]           mem_rd_addr
);
   typedef enum logic [1:0] {st_idle, st_calc, st_mem_wait} eag_state_t;

   eag_state_t                     state_q;
   eag_pkg::eag_op_t               op_q;
   eag_pkg::eag_mode_t             mode_q;
   eag_pkg::eag_size_t             size_q;
   logic [3:0]                     reg_q;
   logic                           bit_from_reg_q;
   logic [eag_pkg::BITNUM_W-1:0]   bit_imm_q;
   logic [eag_pkg::DATA_W-1:0]     ext_q;
   logic [eag_pkg::ADDR_W-1:0]     pc_q;
   logic                           mb1_q;
   logic                           busy_q, done_q, illegal_q, mem_rd_req_q;
   logic [eag_pkg::ADDR_W-1:0]     ea_q, mem_rd_addr_q;
   logic [eag_pkg::DATA_W-1:0]     operand_q;
   logic [eag_pkg::BITNUM_W-1:0]   bit_num_q;
   logic [eag_pkg::TRAP_W-1:0]     trap_vec_q;
   logic                           accept, legal;
   logic [eag_pkg::DATA_W-1:0]     step, sum;
   logic [eag_pkg::ADDR_W-1:0]     raw_addr, addr_d;
   logic [eag_pkg::DATA_W-1:0]     operand_d;
   logic                           wb_en;

   eag_rf_if rf ();

   eag_regfile u_regfile (
      .clk   (clk),
      .rst_n (rst_n),
      .rf    (rf.store)
   );

   // Mode legality per instruction class
   function automatic logic mode_ok(eag_pkg::eag_op_t op, eag_pkg::eag_mode_t m);
      case (op)
         eag_pkg::eag_op_alu:    mode_ok = m inside {eag_pkg::eag_m_reg_direct,
                                                     eag_pkg::eag_m_imm}; // RULE1
         eag_pkg::eag_op_xfer:   mode_ok = !(m inside {eag_pkg::eag_m_pc_rel8,
                                                       eag_pkg::eag_m_pc_rel16,
                                                       eag_pkg::eag_m_mem_ind}); // RULE2
         eag_pkg::eag_op_bit:    mode_ok = m inside {eag_pkg::eag_m_reg_direct,
                                                     eag_pkg::eag_m_reg_ind,
                                                     eag_pkg::eag_m_abs8}; // RULE3
         eag_pkg::eag_op_branch: mode_ok = m inside {eag_pkg::eag_m_pc_rel8,
                                                     eag_pkg::eag_m_pc_rel16};
         eag_pkg::eag_op_jump:   mode_ok = m inside {eag_pkg::eag_m_reg_ind,
                                                     eag_pkg::eag_m_abs24,
                                                     eag_pkg::eag_m_mem_ind};
         eag_pkg::eag_op_trap:   mode_ok = m == eag_pkg::eag_m_imm;
         default:                mode_ok = 1'b0;
      endcase
   endfunction : mode_ok

   function automatic logic [eag_pkg::DATA_W-1:0] step_of(eag_pkg::eag_size_t s);
      case (s)
         eag_pkg::eag_sz_byte: step_of = eag_pkg::STEP_BYTE;
         eag_pkg::eag_sz_word: step_of = eag_pkg::STEP_WORD;
         default:              step_of = eag_pkg::STEP_LONG;
      endcase
   endfunction : step_of

   // Used for register operands and for immediate data alike
   function automatic logic [eag_pkg::DATA_W-1:0] fit_size(logic [eag_pkg::DATA_W-1:0] v,
                                                            eag_pkg::eag_size_t s);
      case (s)
         eag_pkg::eag_sz_byte: fit_size = {24'h000000, v[7:0]};
         eag_pkg::eag_sz_word: fit_size = {16'h0000, v[15:0]};
         default:              fit_size = v;
      endcase
   endfunction : fit_size

   // Alignment first, then the 1-Mbyte cut; both are pure masks so order is free
   function automatic logic [eag_pkg::ADDR_W-1:0] finish(logic [eag_pkg::ADDR_W-1:0] a,
                                                          logic even, logic mb1);
      logic [eag_pkg::ADDR_W-1:0] r;
      r = a;
      if (even) r[0] = 1'b0; // RULE21
      if (mb1) r = r & eag_pkg::MB1_MASK; // RULE22
      finish = r;
   endfunction : finish

   assign accept = (state_q == st_idle) && req_valid && !ext_wr_en;
   assign legal  = mode_ok(op_q, mode_q);
   assign step   = step_of(size_q);

   // Operand and address forming, valid in the calc state
   always_comb begin
      raw_addr  = eag_pkg::RST_ADDR;
      operand_d = eag_pkg::RST_WORD;
      sum       = rf.rd_data;
      wb_en     = 1'b0;
      case (mode_q)
         eag_pkg::eag_m_reg_direct: begin
            case (size_q)
               eag_pkg::eag_sz_byte:
                  operand_d = reg_q[3] ? fit_size(rf.rd_data, eag_pkg::eag_sz_byte) :
                     fit_size(rf.rd_data >> eag_pkg::HI_BYTE_LSB, eag_pkg::eag_sz_byte); // RULE4
               eag_pkg::eag_sz_word:
                  operand_d = reg_q[3] ?
                     fit_size(rf.rd_data >> eag_pkg::EXT_HALF_LSB, eag_pkg::eag_sz_word) :
                     fit_size(rf.rd_data, eag_pkg::eag_sz_word); // RULE4
               default: operand_d = rf.rd_data; // RULE4
            endcase
         end
         eag_pkg::eag_m_reg_ind:  raw_addr = rf.rd_data[23:0]; // RULE5
         eag_pkg::eag_m_disp16: begin
            sum      = rf.rd_data + {{16{ext_q[15]}}, ext_q[15:0]}; // RULE6
            raw_addr = sum[23:0];
         end
         eag_pkg::eag_m_disp24: begin
            sum      = rf.rd_data + {8'h00, ext_q[23:0]}; // RULE6
            raw_addr = sum[23:0];
         end
         eag_pkg::eag_m_post_inc: begin
            raw_addr = rf.rd_data[23:0]; // RULE7
            sum      = rf.rd_data + step; // RULE7
            wb_en    = 1'b1;
         end
         eag_pkg::eag_m_pre_dec: begin
            sum      = rf.rd_data - step; // RULE8
            raw_addr = sum[23:0]; // RULE8
            wb_en    = 1'b1;
         end
         eag_pkg::eag_m_abs8:  raw_addr = {eag_pkg::ABS8_FILL, ext_q[7:0]}; // RULE10
         eag_pkg::eag_m_abs16: raw_addr = {{8{ext_q[15]}}, ext_q[15:0]}; // RULE11
         eag_pkg::eag_m_abs24: raw_addr = ext_q[23:0]; // RULE12
         eag_pkg::eag_m_imm:   operand_d = fit_size(ext_q, size_q); // RULE13
         eag_pkg::eag_m_pc_rel8:
            raw_addr = pc_q + {{16{ext_q[7]}}, ext_q[7:0]}; // RULE16 RULE17
         eag_pkg::eag_m_pc_rel16:
            raw_addr = pc_q + {{8{ext_q[15]}}, ext_q[15:0]}; // RULE16 RULE17
         eag_pkg::eag_m_mem_ind: raw_addr = {eag_pkg::PTR_FILL, ext_q[7:0]}; // RULE20
         default: raw_addr = eag_pkg::RST_ADDR;
      endcase
      addr_d = finish(raw_addr,
                      size_q != eag_pkg::eag_sz_byte || op_q == eag_pkg::eag_op_branch ||
                      op_q == eag_pkg::eag_op_jump || mode_q == eag_pkg::eag_m_mem_ind,
                      mb1_q);
   end

   // Register reads go out with the request; data returns in the calc state
   assign rf.rd_addr  = req_reg[2:0];
   assign rf.rd2_addr = req_bit_reg;
   // Step write-back happens in the calc state, after the old value was used
   assign rf.wr_en    = (state_q == st_calc && legal && wb_en) ||
                        (state_q == st_idle && ext_wr_en); // RULE7 RULE8
   assign rf.wr_addr  = (state_q == st_calc) ? reg_q[2:0] : ext_wr_reg;
   assign rf.wr_data  = (state_q == st_calc) ? sum : ext_wr_data;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q           <= eag_pkg::eag_op_alu;
         mode_q         <= eag_pkg::eag_m_reg_direct;
         size_q         <= eag_pkg::eag_sz_byte;
         reg_q          <= 4'h0;
         bit_from_reg_q <= 1'b0;
         bit_imm_q      <= 3'h0;
         ext_q          <= eag_pkg::RST_WORD;
         pc_q           <= eag_pkg::RST_ADDR;
         mb1_q          <= 1'b0;
      end else if (accept) begin
         op_q           <= req_op;
         mode_q         <= req_mode;
         size_q         <= req_size;
         reg_q          <= req_reg;
         bit_from_reg_q <= req_bit_from_reg;
         bit_imm_q      <= req_bit_imm;
         ext_q          <= req_ext;
         pc_q           <= req_pc_next;
         mb1_q          <= mode_1mb;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= st_idle;
      end else begin
         case (state_q)
            st_idle:     if (accept) state_q <= st_calc;
            st_calc:     state_q <= (legal && mode_q == eag_pkg::eag_m_mem_ind) ?
                                    st_mem_wait : st_idle;
            st_mem_wait: if (mem_rd_valid) state_q <= st_idle;
            default:     state_q <= st_idle;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= accept || (state_q == st_calc && legal &&
                   mode_q == eag_pkg::eag_m_mem_ind) || (state_q == st_mem_wait && !mem_rd_valid);
      end
   end

   // Pointer fetch request stands until the longword returns
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rd_req_q  <= 1'b0;
         mem_rd_addr_q <= eag_pkg::RST_ADDR;
      end else if (state_q == st_calc && legal && mode_q == eag_pkg::eag_m_mem_ind) begin
         mem_rd_req_q  <= 1'b1; // RULE19
         mem_rd_addr_q <= addr_d;
      end else if (mem_rd_valid) begin
         mem_rd_req_q  <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         done_q     <= 1'b0;
         illegal_q  <= 1'b0;
         ea_q       <= eag_pkg::RST_ADDR;
         operand_q  <= eag_pkg::RST_WORD;
         bit_num_q  <= 3'h0;
         trap_vec_q <= 2'h0;
      end else if (state_q == st_calc && !(legal && mode_q == eag_pkg::eag_m_mem_ind)) begin
         done_q     <= 1'b1;
         illegal_q  <= !legal;
         ea_q       <= legal ? addr_d : eag_pkg::RST_ADDR;
         operand_q  <= legal ? operand_d : eag_pkg::RST_WORD;
         bit_num_q  <= bit_from_reg_q ? rf.rd2_data[2:0] : bit_imm_q; // RULE3 RULE14
         trap_vec_q <= ext_q[1:0]; // RULE15
      end else if (state_q == st_mem_wait && mem_rd_valid) begin
         done_q     <= 1'b1;
         illegal_q  <= 1'b0;
         ea_q       <= finish(mem_rd_data[23:0], 1'b1, mb1_q); // RULE19 RULE21 RULE22
         operand_q  <= eag_pkg::RST_WORD;
      end else begin
         done_q     <= 1'b0;
      end
   end

   assign busy        = busy_q;
   assign done        = done_q;
   assign illegal     = illegal_q;
   assign ea          = ea_q;
   assign operand     = operand_q;
   assign bit_num     = bit_num_q;
   assign trap_vec    = trap_vec_q;
   assign mem_rd_req  = mem_rd_req_q;
   assign mem_rd_addr = mem_rd_addr_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_accept_simple;
      accept && req_mode != eag_pkg::eag_m_mem_ind;
   endsequence
   sequence s_post_long;
      accept && req_mode == eag_pkg::eag_m_post_inc && req_op == eag_pkg::eag_op_xfer &&
      req_size == eag_pkg::eag_sz_long;
   endsequence
   sequence s_ptr_return;
      state_q == st_mem_wait && mem_rd_valid && !mb1_q;
   endsequence

   property p_latency;
      s_accept_simple |-> ##1 !done ##1 done;
   endproperty
   a_latency: assert property (p_latency) else $error("done not two cycles after request"); // LATENCY of eag_pkg

   property p_alu_modes;
      done && $past(op_q) == eag_pkg::eag_op_alu &&
      !($past(mode_q) inside {eag_pkg::eag_m_reg_direct, eag_pkg::eag_m_imm}) |-> illegal;
   endproperty
   a_alu_modes: assert property (p_alu_modes) else $error("alu mode not refused"); // RULE1

   property p_post_step;
      s_post_long |-> ##1 (rf.wr_en && rf.wr_data == rf.rd_data + 32'h00000004)
                      ##1 (done &&
                           ea == finish($past(rf.wr_data[23:0]) - 24'h000004, 1'b1, mb1_q));
   endproperty
   a_post_step: assert property (p_post_step) else $error("post-increment step wrong"); // RULE7

   property p_pre_dec;
      done && !illegal && $past(mode_q) == eag_pkg::eag_m_pre_dec &&
      $past(size_q) == eag_pkg::eag_sz_byte && !$past(mb1_q) |->
         ea == $past(rf.wr_data[23:0]);
   endproperty
   a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement address wrong"); // RULE8

   property p_abs8;
      done && !illegal && $past(mode_q) == eag_pkg::eag_m_abs8 && !$past(mb1_q) |->
         ea[23:8] == 16'hffff;
   endproperty
   a_abs8: assert property (p_abs8) else $error("short absolute fill wrong"); // RULE10

   property p_branch_reach;
      done && !illegal && $past(mode_q) == eag_pkg::eag_m_pc_rel8 && !$past(mb1_q) |->
         ($signed(ea - $past(pc_q)) >= -24'sd128 && $signed(ea - $past(pc_q)) <= 24'sd126);
   endproperty
   a_branch_reach: assert property (p_branch_reach) else $error("short branch out of reach"); // RULE17

   property p_even;
      done && !illegal && ($past(size_q) != eag_pkg::eag_sz_byte ||
      $past(op_q) inside {eag_pkg::eag_op_branch, eag_pkg::eag_op_jump}) |-> !ea[0];
   endproperty
   a_even: assert property (p_even) else $error("odd address not forced even"); // RULE21

   property p_mb1;
      done && mb1_q |-> ea[23:20] == 4'h0;
   endproperty
   a_mb1: assert property (p_mb1) else $error("upper address bits not dropped"); // RULE22

   property p_ptr_fetch;
      s_ptr_return |-> mem_rd_req && mem_rd_addr[23:8] == 16'h0000
                       ##1 (done && ea == {$past(mem_rd_data[23:1]), 1'b0});
   endproperty
   a_ptr_fetch: assert property (p_ptr_fetch) else $error("pointer target wrong"); // RULE19 RULE20

endmodule : eag_top

// file: verification/eag_top_tb_top.sv
// Self-checking bench for the effective address generator
`timescale 1ns/1ps
module eag_top_tb_top;
   localparam eag_pkg::eag_op_t ALU = eag_pkg::eag_op_alu, XF = eag_pkg::eag_op_xfer,
      BT = eag_pkg::eag_op_bit, BR = eag_pkg::eag_op_branch, JP = eag_pkg::eag_op_jump,
      TR = eag_pkg::eag_op_trap;
   localparam eag_pkg::eag_mode_t DIR = eag_pkg::eag_m_reg_direct,
      IND = eag_pkg::eag_m_reg_ind, D16 = eag_pkg::eag_m_disp16, D24 = eag_pkg::eag_m_disp24,
      PI = eag_pkg::eag_m_post_inc, PD = eag_pkg::eag_m_pre_dec, A8 = eag_pkg::eag_m_abs8,
      A16 = eag_pkg::eag_m_abs16, A24 = eag_pkg::eag_m_abs24, IMM = eag_pkg::eag_m_imm,
      R8 = eag_pkg::eag_m_pc_rel8, R16 = eag_pkg::eag_m_pc_rel16, MI = eag_pkg::eag_m_mem_ind;
   localparam eag_pkg::eag_size_t SB = eag_pkg::eag_sz_byte, SW = eag_pkg::eag_sz_word,
      SL = eag_pkg::eag_sz_long;

   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               req_valid = 1'b0;
   eag_pkg::eag_op_t   req_op = ALU;
   eag_pkg::eag_mode_t req_mode = DIR;
   eag_pkg::eag_size_t req_size = SB;
   logic [3:0]         req_reg = 4'h0;
   logic [2:0]         req_bit_reg = 3'h0;
   logic               req_bit_from_reg = 1'b0;
   logic [2:0]         req_bit_imm = 3'h0;
   logic [31:0]        req_ext = 32'h0;
   logic [23:0]        req_pc_next = 24'h0;
   logic               mode_1mb = 1'b0;
   logic               ext_wr_en = 1'b0;
   logic [2:0]         ext_wr_reg = 3'h0;
   logic [31:0]        ext_wr_data = 32'h0;
   logic               mem_rd_valid = 1'b0;
   logic [31:0]        mem_rd_data = 32'h0;
   logic               busy, done, illegal, mem_rd_req;
   logic [23:0]        ea, mem_rd_addr, ptr_seen;
   logic [31:0]        operand, ptr_v;
   logic [2:0]         bit_num;
   logic [2:0]         bitreg_v = 3'h0, bimm_v = 3'h0;
   logic [1:0]         trap_vec;
   logic [23:0]        pc_v = 24'h0;
   logic               mb_v = 1'b0, bsrc_v = 1'b0;
   int                 mismatches = 0;
   int                 n_tests = 0;

   eag_top u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
      .req_mode(req_mode), .req_size(req_size), .req_reg(req_reg), .req_bit_reg(req_bit_reg),
      .req_bit_from_reg(req_bit_from_reg), .req_bit_imm(req_bit_imm), .req_ext(req_ext),
      .req_pc_next(req_pc_next), .mode_1mb(mode_1mb), .ext_wr_en(ext_wr_en),
      .ext_wr_reg(ext_wr_reg), .ext_wr_data(ext_wr_data), .mem_rd_valid(mem_rd_valid),
      .mem_rd_data(mem_rd_data), .busy(busy), .done(done), .illegal(illegal), .ea(ea),
      .operand(operand), .bit_num(bit_num), .trap_vec(trap_vec), .mem_rd_req(mem_rd_req),
      .mem_rd_addr(mem_rd_addr));

   always #5 clk = ~clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim;
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim

   task automatic wr(input logic [2:0] r, input logic [31:0] d);
      @(posedge clk);
      ext_wr_en <= 1'b1;
      ext_wr_reg <= r;
      ext_wr_data <= d;
      @(posedge clk);
      ext_wr_en <= 1'b0;
   endtask : wr

   // One request, held until the accepting edge; the pointer fetch is answered a cycle late
   task automatic run(input eag_pkg::eag_op_t op, input eag_pkg::eag_mode_t md,
                      input eag_pkg::eag_size_t sz, input logic [3:0] rg, input logic [31:0] x);
      int  n;
      bit  sent;
      n = 0;
      sent = 1'b0;
      @(posedge clk);
      req_op <= op;
      req_mode <= md;
      req_size <= sz;
      {req_reg, req_ext} <= {rg, x};
      {req_pc_next, mode_1mb, req_bit_from_reg} <= {pc_v, mb_v, bsrc_v};
      {req_bit_reg, req_bit_imm} <= {bitreg_v, bimm_v};
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      do begin
         @(posedge clk);
         #1;
         n++;
         if (mem_rd_req === 1'b1 && !sent) begin
            sent = 1'b1;
            ptr_seen = mem_rd_addr;
            @(posedge clk);
            mem_rd_valid <= 1'b1;
            mem_rd_data <= ptr_v;
            @(posedge clk);
            mem_rd_valid <= 1'b0;
            mem_rd_data <= ~ptr_v;
            #1;
         end
      end while (done !== 1'b1 && n < 40);
      check(done, 1'b1);
      // n counts to the edge that launches done; the latency counts to the edge that samples it
      if (md != MI) check(n + 1, eag_pkg::LATENCY);
   endtask : run

   task automatic t_direct;
      wr(3'd3, 32'h89abcdef);
      run(ALU, DIR, SL, 4'h3, 0); check(operand, 32'h89abcdef);
      run(ALU, DIR, SB, 4'h3, 0); check(operand[7:0], 8'hcd);
      run(ALU, DIR, SB, 4'hb, 0); check(operand[7:0], 8'hef);
      run(ALU, DIR, SW, 4'h3, 0); check(operand[15:0], 16'hcdef);
      run(ALU, DIR, SW, 4'hb, 0); check(operand[15:0], 16'h89ab);
      run(ALU, IMM, SB, 0, 32'h000000a5); check(operand, 32'h000000a5);
      run(ALU, IMM, SW, 0, 32'h0000beef); check(operand, 32'h0000beef);
      run(ALU, IMM, SL, 0, 32'h12345678); check(operand, 32'h12345678);
      bsrc_v = 1'b1;
      bitreg_v = 3'd3;
      run(BT, IND, SB, 4'h3, 0); check(bit_num, 3'd7);
      bsrc_v = 1'b0;
      for (int b = 0; b < 8; b++) begin
         bimm_v = b[2:0];
         run(BT, A8, SB, 0, 32'h10); check(bit_num, b[2:0]);
      end
      for (int t = 0; t < 4; t++) begin
         run(TR, IMM, SB, 0, t); check(trap_vec, t[1:0]);
      end
   endtask : t_direct

   task automatic t_addr;
      wr(3'd2, 32'h12345679);
      run(XF, IND, SB, 4'h2, 0); check(ea, 24'h345679);
      run(XF, IND, SW, 4'h2, 0); check(ea, 24'h345678);
      run(XF, D16, SB, 4'h2, 32'h0000fffe); check(ea, 24'h345677);
      run(XF, D24, SB, 4'h2, 32'h00100000); check(ea, 24'h445679);
      run(XF, A8, SB, 0, 32'h12); check(ea, 24'hffff12);
      run(XF, A16, SB, 0, 32'h8000); check(ea, 24'hff8000);
      run(XF, A16, SB, 0, 32'h7fff); check(ea, 24'h007fff);
      run(XF, A24, SB, 0, 32'habcdef); check(ea, 24'habcdef);
      mb_v = 1'b1;
      run(XF, D24, SB, 4'h2, 32'h00100000); check(ea, 24'h045679);
      run(XF, A8, SB, 0, 32'h12); check(ea, 24'h0fff12);
      mb_v = 1'b0;
   endtask : t_addr

   task automatic t_step;
      wr(3'd4, 32'h00fffffe);
      run(XF, PI, SL, 4'h4, 0); check(ea, 24'hfffffe);
      run(ALU, DIR, SL, 4'h4, 0); check(operand, 32'h01000002);
      run(XF, PD, SW, 4'h4, 0); check(ea, 24'h000000);
      run(ALU, DIR, SL, 4'h4, 0); check(operand, 32'h01000000);
      run(XF, PI, SB, 4'h4, 0); check(ea, 24'h000000);
      run(ALU, DIR, SL, 4'h4, 0); check(operand, 32'h01000001);
      run(XF, PD, SB, 4'h4, 0); check(ea, 24'h000000);
      run(ALU, DIR, SL, 4'h4, 0); check(operand, 32'h01000000);
   endtask : t_step

   task automatic t_flow;
      pc_v = 24'h001000;
      run(BR, R8, SB, 0, 32'h80); check(ea, 24'h000f80);
      run(BR, R8, SB, 0, 32'h7f); check(ea, 24'h00107e);
      run(BR, R16, SB, 0, 32'h8002); check(ea, 24'hff9002);
      run(BR, R16, SB, 0, 32'h7ffe); check(ea, 24'h008ffe);
      ptr_v = 32'hff123457;
      run(JP, MI, SL, 0, 32'h00ffff41); check(ptr_seen, 24'h000040);
      check(ea, 24'h123456);
      run(JP, A24, SB, 0, 32'h00123457); check(ea, 24'h123456);
      run(ALU, IND, SB, 4'h2, 0); check({illegal, ea}, 25'h1000000);
      run(XF, R8, SB, 0, 32'h2); check(illegal, 1'b1);
      run(XF, MI, SL, 0, 32'h40); check(illegal, 1'b1);
      run(BT, D16, SB, 4'h2, 0); check(illegal, 1'b1);
      run(ALU, IMM, SB, 0, 32'h1); check(illegal, 1'b0);
   endtask : t_flow

   initial begin
      #200000;
      mismatches++;
      end_sim();
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      check({done, busy, mem_rd_req}, 3'b000);
      t_direct();
      t_addr();
      t_step();
      t_flow();
      end_sim();
   end
endmodule : eag_top_tb_top
